// file: deacc_pkg.sv
// package: constants and types for the data store access controller
`default_nettype none

package deacc_pkg;

	// =========================================================
	// widths and sizes
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned LO_W       = 8;
	localparam int unsigned HI_W       = 6;
	localparam int unsigned ADDR_W     = 14;
	localparam int unsigned OFFS_W     = 6;
	localparam int unsigned PAGE_BYTES = 64;
	localparam int unsigned MEM_BYTES  = 16384;
	localparam int unsigned CTRL_W     = 5;
	localparam logic [5:0]  OFFS_MAX   = 6'h3f;

	// =========================================================
	// control field positions
	localparam int unsigned CTRL_RSTART = 0;
	localparam int unsigned CTRL_RPERM  = 1;
	localparam int unsigned CTRL_PSTART = 2;
	localparam int unsigned CTRL_PPERM  = 3;
	localparam int unsigned CTRL_MODE   = 4;

	// =========================================================
	// reset values
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [7:0] LO_RST   = 8'h00;
	localparam logic [5:0] HI_RST   = 6'h00;
	localparam logic [7:0] PORT_RST = 8'h00;

	// =========================================================
	// timing
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned WR_TIME_US    = 2000;
	localparam int unsigned WR_CYCLES     =
		(WR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WR_CNT_W      = 20;

	// =========================================================
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD_ISSUE,
		ST_RD_CAPT,
		ST_RD_END,
		ST_WR_COMMIT,
		ST_WR_TIME
	} deacc_state_t;

endpackage

`default_nettype wire

// file: deacc_store.sv
// module: byte-wide nonvolatile cell array model, registered read port
`timescale 1ns/100ps
`default_nettype none

module deacc_store
	import deacc_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              rd_en,
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wr_data,
	output logic      [DATA_W-1:0] rd_data
);

	// =========================================================
	// state
	typedef struct packed {
		logic [DATA_W-1:0] rd_data;
	} deacc_store_t;

	deacc_store_t      s_q;
	deacc_store_t      s_d;
	logic [DATA_W-1:0] cells [MEM_BYTES];

	// =========================================================
	// read port
	always_comb
	begin
		s_d = s_q;
		if (rd_en)
			s_d.rd_data = cells[addr];
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// =========================================================
	// write port, cells keep contents through reset
	always_ff @(posedge core_clk)
	begin
		if (wr_en)
			cells[addr] <= wr_data;
	end

	assign rd_data = s_q.rd_data;

endmodule

`default_nettype wire

// file: deacc_pagebuf.sv
// module: 64-byte page buffer with per-entry fill marks
`timescale 1ns/100ps
`default_nettype none

module deacc_pagebuf
	import deacc_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              clear,
	input  wire logic              ld_en,
	input  wire logic [OFFS_W-1:0] ld_idx,
	input  wire logic [DATA_W-1:0] ld_data,
	input  wire logic [OFFS_W-1:0] rd_idx,
	output logic      [DATA_W-1:0] rd_data,
	output logic                   rd_valid
);

	// =========================================================
	// state
	typedef struct packed {
		logic [PAGE_BYTES-1:0] valid;
	} deacc_pb_t;

	deacc_pb_t         pb_q;
	deacc_pb_t         pb_d;
	logic [DATA_W-1:0] slots [PAGE_BYTES];

	always_comb
	begin
		pb_d = pb_q;
		if (clear)
			pb_d.valid = '0;
		else if (ld_en)
			pb_d.valid[ld_idx] = 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			pb_q <= '0;
		else
			pb_q <= pb_d;
	end

	always_ff @(posedge core_clk)
	begin
		if (ld_en && !clear)
			slots[ld_idx] <= ld_data;
	end

	// empty entries read as zero
	assign rd_valid = pb_q.valid[rd_idx];
	assign rd_data  = pb_q.valid[rd_idx] ? slots[rd_idx] : '0;

	// =========================================================
	// checks
	property p_buf_cleared;
		@(posedge core_clk) disable iff (reset)
		clear |=> (pb_q.valid == '0);
	endproperty
	a_buf_cleared: assert property (p_buf_cleared)
		else $error("page buffer not empty after clear");

endmodule

`default_nettype wire

// file: deacc_top.sv
// module: data store access controller, register ports and sequencer
`timescale 1ns/100ps
`default_nettype none

module deacc_top
	import deacc_pkg::*;
#(
	parameter int unsigned WR_CYCLES_P = WR_CYCLES
)
(
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              ctrl_wr,
	input  wire logic [CTRL_W-1:0] ctrl_wdata,
	input  wire logic              lo_wr,
	input  wire logic [LO_W-1:0]   lo_wdata,
	input  wire logic              hi_wr,
	input  wire logic [HI_W-1:0]   hi_wdata,
	input  wire logic              port_wr,
	input  wire logic [DATA_W-1:0] port_wdata,
	input  wire logic              global_irq_enable,
	input  wire logic              nvm_irq_enable,
	input  wire logic              shared_irq_enable,
	input  wire logic              irq_service,
	input  wire logic              flag_clear,
	output logic                   op_mode,
	output logic                   program_permit,
	output logic                   program_start,
	output logic                   read_permit,
	output logic                   read_start,
	output logic      [LO_W-1:0]   cell_index_low,
	output logic      [HI_W-1:0]   cell_index_high,
	output logic      [DATA_W-1:0] cell_byte_port,
	output logic                   nvm_irq_flag,
	output logic                   shared_irq_flag,
	output logic                   irq_request
);

	// =========================================================
	// state
	typedef struct packed {
		deacc_state_t        state;
		logic                mode;
		logic                wperm;
		logic                wstart;
		logic                rperm;
		logic                rstart;
		logic [LO_W-1:0]     lo;
		logic [HI_W-1:0]     hi;
		logic [DATA_W-1:0]   port;
		logic                done;
		logic                shared;
		logic                irq;
		logic [OFFS_W-1:0]   cidx;
		logic [WR_CNT_W-1:0] cnt;
	} deacc_top_t;

	deacc_top_t        st_q;
	deacc_top_t        st_d;
	logic              mem_rd;
	logic              mem_wr;
	logic [ADDR_W-1:0] mem_addr;
	logic [DATA_W-1:0] mem_wdata;
	logic [DATA_W-1:0] mem_rdata;
	logic              pb_ld;
	logic              pb_clear;
	logic [DATA_W-1:0] pb_data;
	logic              pb_valid;

	localparam logic [WR_CNT_W-1:0] WR_LAST = WR_CNT_W'(WR_CYCLES_P - 1);

	// =========================================================
	// in-page offset step, saturating at the page end
	function automatic logic [LO_W-1:0] next_lo(input logic [LO_W-1:0] lo);
		logic [OFFS_W-1:0] offs;
		offs = lo[OFFS_W-1:0];
		if (offs != OFFS_MAX)
			offs = offs + 6'h01;
		return {lo[LO_W-1:OFFS_W], offs};
	endfunction

	// =========================================================
	// sequencer
	always_comb
	begin
		st_d      = st_q;
		mem_rd    = 1'b0;
		mem_wr    = 1'b0;
		mem_addr  = {st_q.hi, st_q.lo};
		mem_wdata = st_q.port;
		pb_ld     = 1'b0;

		// software clears come first so hardware sets win
		if (flag_clear)
			st_d.done = 1'b0;
		if (irq_service)
			st_d.shared = 1'b0;

		// register writes while idle
		if (st_q.state == ST_IDLE)
		begin
			if (lo_wr)
				st_d.lo = lo_wdata;
			if (hi_wr)
				st_d.hi = hi_wdata;
			if (port_wr)
			begin
				st_d.port = port_wdata;
				if (st_q.mode)
				begin
					pb_ld   = 1'b1;
					st_d.lo = next_lo(st_q.lo);
				end
			end
			if (ctrl_wr)
			begin
				st_d.mode  = ctrl_wdata[CTRL_MODE];
				st_d.rperm = ctrl_wdata[CTRL_RPERM];
				st_d.wperm = ctrl_wdata[CTRL_PPERM];
				// program start wins if both starts arrive
				if (ctrl_wdata[CTRL_PSTART] && st_q.wperm)
				begin
					st_d.wstart = 1'b1;
					st_d.wperm  = 1'b1;
					st_d.cidx   = '0;
					st_d.cnt    = '0;
					st_d.state  = ST_WR_COMMIT;
				end
				else if (ctrl_wdata[CTRL_RSTART] && st_q.rperm)
				begin
					st_d.rstart = 1'b1;
					st_d.state  = ST_RD_ISSUE;
				end
			end
		end
		else if (ctrl_wr)
		begin
			// starts and mode ignored while busy
			st_d.rperm = ctrl_wdata[CTRL_RPERM];
			if (!st_q.wstart)
				st_d.wperm = ctrl_wdata[CTRL_PPERM];
		end

		unique case (st_q.state)
			ST_IDLE:
			begin
			end
			ST_RD_ISSUE:
			begin
				mem_rd     = 1'b1;
				st_d.state = ST_RD_CAPT;
			end
			ST_RD_CAPT:
			begin
				st_d.port = mem_rdata;
				if (st_q.mode)
					st_d.lo = next_lo(st_q.lo);
				st_d.state = ST_RD_END;
			end
			ST_RD_END:
			begin
				st_d.rstart = 1'b0;
				st_d.state  = ST_IDLE;
			end
			ST_WR_COMMIT:
			begin
				if (!st_q.mode)
				begin
					mem_wr     = 1'b1;
					st_d.state = ST_WR_TIME;
				end
				else
				begin
					mem_addr  = {st_q.hi, st_q.lo[LO_W-1:OFFS_W], st_q.cidx};
					mem_wdata = pb_data;
					mem_wr    = pb_valid;
					st_d.cidx = st_q.cidx + 6'h01;
					if (st_q.cidx == OFFS_MAX)
						st_d.state = ST_WR_TIME;
				end
			end
			ST_WR_TIME:
			begin
				st_d.cnt = st_q.cnt + 20'h00001;
				if (st_q.cnt == WR_LAST)
				begin
					st_d.wstart = 1'b0;
					st_d.wperm  = 1'b0;
					st_d.done   = 1'b1;
					st_d.shared = 1'b1;
					st_d.cnt    = '0;
					st_d.state  = ST_IDLE;
				end
			end
			default:
			begin
				st_d.state = ST_IDLE;
			end
		endcase

		st_d.irq = st_d.done && st_d.shared && global_irq_enable
			&& nvm_irq_enable && shared_irq_enable;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign pb_clear = st_q.wperm && !st_d.wperm;

	// =========================================================
	// storage and page buffer
	deacc_store u_store (
		.core_clk (core_clk),
		.reset    (reset),
		.rd_en    (mem_rd),
		.wr_en    (mem_wr),
		.addr     (mem_addr),
		.wr_data  (mem_wdata),
		.rd_data  (mem_rdata)
	);

	deacc_pagebuf u_pagebuf (
		.core_clk (core_clk),
		.reset    (reset),
		.clear    (pb_clear),
		.ld_en    (pb_ld),
		.ld_idx   (st_q.lo[OFFS_W-1:0]),
		.ld_data  (port_wdata),
		.rd_idx   (st_q.cidx),
		.rd_data  (pb_data),
		.rd_valid (pb_valid)
	);

	// =========================================================
	// outputs
	assign op_mode         = st_q.mode;
	assign program_permit  = st_q.wperm;
	assign program_start   = st_q.wstart;
	assign read_permit     = st_q.rperm;
	assign read_start      = st_q.rstart;
	assign cell_index_low  = st_q.lo;
	assign cell_index_high = st_q.hi;
	assign cell_byte_port  = st_q.port;
	assign nvm_irq_flag    = st_q.done;
	assign shared_irq_flag = st_q.shared;
	assign irq_request     = st_q.irq;

	// =========================================================
	// checks
	property p_rd_permit;
		@(posedge core_clk) disable iff (reset)
		$rose(st_q.rstart) |-> $past(st_q.rperm);
	endproperty
	a_rd_permit: assert property (p_rd_permit)
		else $error("read started without permit");

	property p_rd_clear;
		@(posedge core_clk) disable iff (reset)
		$rose(st_q.rstart) |-> st_q.rstart [*3] ##1 !st_q.rstart;
	endproperty
	a_rd_clear: assert property (p_rd_clear)
		else $error("read start not cleared on time");

	property p_rd_data;
		@(posedge core_clk) disable iff (reset)
		st_q.state == ST_RD_CAPT |=> st_q.port == $past(mem_rdata)
			&& st_q.rstart;
	endproperty
	a_rd_data: assert property (p_rd_data)
		else $error("fetched byte missing before start clears");

	property p_page_step;
		@(posedge core_clk) disable iff (reset)
		(st_q.state == ST_RD_CAPT && st_q.mode) |=>
			st_q.lo == next_lo($past(st_q.lo)) && st_q.hi == $past(st_q.hi);
	endproperty
	a_page_step: assert property (p_page_step)
		else $error("page read address step wrong");

	property p_saturate;
		@(posedge core_clk) disable iff (reset)
		(st_q.state == ST_RD_CAPT && st_q.lo[OFFS_W-1:0] == OFFS_MAX)
			|=> st_q.lo[OFFS_W-1:0] == OFFS_MAX;
	endproperty
	a_saturate: assert property (p_saturate)
		else $error("in-page offset rolled over");

	property p_wr_permit;
		@(posedge core_clk) disable iff (reset)
		$rose(st_q.wstart) |-> $past(st_q.wperm);
	endproperty
	a_wr_permit: assert property (p_wr_permit)
		else $error("write started without permit");

	property p_wr_end;
		@(posedge core_clk) disable iff (reset)
		$fell(st_q.wstart) |-> !st_q.wperm && st_q.done && st_q.shared;
	endproperty
	a_wr_end: assert property (p_wr_end)
		else $error("write end left permit or flags wrong");

	property p_busy_hold;
		@(posedge core_clk) disable iff (reset)
		(st_q.state != ST_IDLE && ctrl_wr) |=>
			!$rose(st_q.rstart) && !$rose(st_q.wstart)
			&& st_q.mode == $past(st_q.mode);
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("start accepted while busy");

	property p_irq;
		@(posedge core_clk) disable iff (reset)
		(st_q.done && st_q.shared && global_irq_enable && nvm_irq_enable
			&& shared_irq_enable && !flag_clear && !irq_service)
			|=> irq_request;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt request not raised");

	property p_service;
		@(posedge core_clk) disable iff (reset)
		(irq_service && st_q.state != ST_WR_TIME && st_q.done && !flag_clear)
			|=> !st_q.shared && st_q.done;
	endproperty
	a_service: assert property (p_service)
		else $error("service cleared wrong flag");

endmodule

`default_nettype wire

// file: tb.sv
// testbench: random and corner stimulus for the access controller
`timescale 1ns/100ps
`default_nettype none

module tb
	import deacc_pkg::*;
;

	// ==========================================
	// signals
	localparam int unsigned WRC = 8;
	logic              core_clk;
	logic              reset;
	logic              ctrl_wr;
	logic [CTRL_W-1:0] ctrl_wdata;
	logic              lo_wr;
	logic [LO_W-1:0]   lo_wdata;
	logic              hi_wr;
	logic [HI_W-1:0]   hi_wdata;
	logic              port_wr;
	logic [DATA_W-1:0] port_wdata;
	logic              irq_service;
	logic              flag_clear;
	logic              global_irq_enable;
	logic              nvm_irq_enable;
	logic              shared_irq_enable;
	logic              op_mode;
	logic              program_permit;
	logic              program_start;
	logic              read_permit;
	logic              read_start;
	logic [LO_W-1:0]   cell_index_low;
	logic [HI_W-1:0]   cell_index_high;
	logic [DATA_W-1:0] cell_byte_port;
	logic              nvm_irq_flag;
	logic              shared_irq_flag;
	logic              irq_request;
	int                err_count;
	int                checks_done;
	logic [31:0]       rs;
	logic [13:0]       a;
	logic [13:0]       base;
	logic [7:0]        d;
	logic [7:0]        b0;
	logic [7:0]        b2;
	logic [2:0]        en;

	deacc_top #(
		.WR_CYCLES_P (WRC)
	) i_deacc_top (
		.core_clk          (core_clk),
		.reset             (reset),
		.ctrl_wr           (ctrl_wr),
		.ctrl_wdata        (ctrl_wdata),
		.lo_wr             (lo_wr),
		.lo_wdata          (lo_wdata),
		.hi_wr             (hi_wr),
		.hi_wdata          (hi_wdata),
		.port_wr           (port_wr),
		.port_wdata        (port_wdata),
		.global_irq_enable (global_irq_enable),
		.nvm_irq_enable    (nvm_irq_enable),
		.shared_irq_enable (shared_irq_enable),
		.irq_service       (irq_service),
		.flag_clear        (flag_clear),
		.op_mode           (op_mode),
		.program_permit    (program_permit),
		.program_start     (program_start),
		.read_permit       (read_permit),
		.read_start        (read_start),
		.cell_index_low    (cell_index_low),
		.cell_index_high   (cell_index_high),
		.cell_byte_port    (cell_byte_port),
		.nvm_irq_flag      (nvm_irq_flag),
		.shared_irq_flag   (shared_irq_flag),
		.irq_request       (irq_request)
	);

	// ==========================================
	// helpers
	function automatic logic [31:0] nxt(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	task automatic finish_test;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] ex,
		input logic [15:0] got);
		checks_done++;
		if (got !== ex)
		begin
			$display("wrong value %s expected %h seen %h", nm, ex, got);
			err_count++;
		end
	endtask

	task automatic step;
		@(posedge core_clk);
		#1;
	endtask

	task automatic ctrl(input logic [4:0] v);
		ctrl_wr = 1'b1;
		ctrl_wdata = v;
		step;
		ctrl_wr = 1'b0;
		step;
	endtask

	task automatic adr(input logic [13:0] v);
		lo_wr = 1'b1;
		hi_wr = 1'b1;
		lo_wdata = v[7:0];
		hi_wdata = v[13:8];
		step;
		lo_wr = 1'b0;
		hi_wr = 1'b0;
		step;
	endtask

	task automatic port(input logic [7:0] v);
		port_wr = 1'b1;
		port_wdata = v;
		step;
		port_wr = 1'b0;
		step;
	endtask

	task automatic wait_idle;
		int i;
		for (i = 0; i < 400 && (read_start !== 1'b0
			|| program_start !== 1'b0); i++)
			step;
		if (i == 400)
		begin
			$display("wrong value busy expected 0 seen 1");
			err_count++;
			finish_test;
		end
	endtask

	// byte write; permit then start, never both starts
	task automatic wr(input logic [13:0] ad, input logic [7:0] v);
		ctrl(5'h00);
		adr(ad);
		port(v);
		global_irq_enable = 1'b0;
		ctrl(5'h08);
		ctrl(5'h0c);
		global_irq_enable = 1'b1;
		wait_idle;
	endtask

	task automatic rd(input logic m, input logic [7:0] ex);
		ctrl({m, 4'h2});
		ctrl({m, 4'h3});
		wait_idle;
		chk("byte_port", 16'(ex), 16'(cell_byte_port));
	endtask

	function automatic logic [15:0] cur_adr;
		return 16'({cell_index_high, cell_index_low});
	endfunction

	// ==========================================
	// clock and sequence
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	initial
	begin
		reset = 1'b1;
		ctrl_wr = 1'b0;
		ctrl_wdata = 5'h00;
		lo_wr = 1'b0;
		lo_wdata = 8'h00;
		hi_wr = 1'b0;
		hi_wdata = 6'h00;
		port_wr = 1'b0;
		port_wdata = 8'h00;
		irq_service = 1'b0;
		flag_clear = 1'b0;
		global_irq_enable = 1'b1;
		nvm_irq_enable = 1'b1;
		shared_irq_enable = 1'b1;
		err_count = 0;
		checks_done = 0;
		rs = 32'ha1a2;
		repeat (12) @(posedge core_clk);
		#1;
		reset = 1'b0;
		step;
		chk("control", 16'h0000, 16'({op_mode, program_permit,
			program_start, read_permit, read_start}));
		ctrl(5'h03);
		chk("read_start", 16'h0000, 16'(read_start));
		ctrl(5'h0c);
		chk("program_start", 16'h0000, 16'(program_start));
		for (int k = 0; k < 6; k++)
		begin
			rs = nxt(rs);
			a = (k == 0) ? 14'h0000 : (k == 1) ? 14'h3fff : rs[13:0];
			d = rs[31:24];
			wr(a, d);
			chk("permit", 16'h0000, 16'(program_permit));
			chk("done_flag", 16'h0001, 16'(nvm_irq_flag));
			chk("shared_flag", 16'h0001, 16'(shared_irq_flag));
			step;
			chk("irq_request", 16'h0001, 16'(irq_request));
			en = 3'h7 ^ (3'h1 << (k % 3));
			{global_irq_enable, nvm_irq_enable, shared_irq_enable} = en;
			step;
			chk("irq_request", 16'h0000, 16'(irq_request));
			{global_irq_enable, nvm_irq_enable, shared_irq_enable} = 3'h7;
			irq_service = 1'b1;
			step;
			irq_service = 1'b0;
			chk("shared_flag", 16'h0000, 16'(shared_irq_flag));
			chk("done_flag", 16'h0001, 16'(nvm_irq_flag));
			flag_clear = 1'b1;
			step;
			flag_clear = 1'b0;
			chk("done_flag", 16'h0000, 16'(nvm_irq_flag));
			adr(a);
			rd(1'b0, d);
			chk("address", 16'(a), cur_adr());
			adr(~a);
			chk("byte_port", 16'(d), 16'(cell_byte_port));
		end
		// page write from offset 3e, third byte lands on 3f
		rs = nxt(rs);
		base = {rs[13:6], 6'h3e};
		b0 = rs[7:0];
		b2 = rs[23:16];
		ctrl(5'h10);
		adr(base);
		port(b0);
		chk("address", 16'(base) + 16'h1, cur_adr());
		port(rs[15:8]);
		port(b2);
		chk("address", 16'(base) + 16'h1, cur_adr());
		ctrl(5'h18);
		chk("control", 16'h0018, 16'({op_mode, program_permit,
			program_start, read_permit, read_start}));
		ctrl(5'h1c);
		adr(14'h0000);
		chk("address", 16'(base) + 16'h1, cur_adr());
		ctrl(5'h03);
		chk("read_start", 16'h0000, 16'(read_start));
		chk("mode", 16'h0001, 16'(op_mode));
		chk("read_permit", 16'h0001, 16'(read_permit));
		wait_idle;
		chk("permit", 16'h0000, 16'(program_permit));
		adr(base);
		rd(1'b1, b0);
		chk("address", 16'(base) + 16'h1, cur_adr());
		rd(1'b1, b2);
		chk("address", 16'(base) + 16'h1, cur_adr());
		// permit falling empties the loaded buffer
		d = rs[31:24];
		wr(base, d);
		ctrl(5'h10);
		adr(base);
		port(~d);
		ctrl(5'h18);
		ctrl(5'h10);
		ctrl(5'h18);
		ctrl(5'h1c);
		wait_idle;
		adr(base);
		rd(1'b0, d);
		finish_test;
	end

endmodule

`default_nettype wire
